// [rtl/fpulhc_unit.sv]
// How it works
// (RULE_01) Result readable delay-slot count plus one cycles after operand read.
// (RULE_02) Four-cycle class reads on i, writes on i + 3.
// (RULE_03) Unit latency equals read-port occupancy cycles.
// (RULE_04) dp_add and dp_sub read on i and i + 1; next issue from i + 2.
// (RULE_05) dp_add and dp_sub write i + 5, i + 6; readable i + 7.
// (RULE_06) Fixed-point shared instructions occupy read ports one cycle only.
// (RULE_07) Cycle i is the issue cycle, execute_phase_one.
// (RULE_08) Load writes at i + 4 on its own write port.
// (RULE_09) Dispatcher must not issue into a locked unit.
// (RULE_10) False predicate still locks the unit.
// (RULE_11) DP compare and add lock two cycles; 32-bit and dp multiplies four.
// (RULE_12) Cross path of a multicycle instruction is reserved while it locks.
// (RULE_13) Same-cycle read or write port use by two instructions is a hazard.
// (RULE_14) After two-cycle DP, no single or two-cycle DP at i + 1.
// (RULE_15) After four-cycle, no single at i + 3, no 16x16 multiply at i + 2.
// (RULE_16) After int_to_dp_convert, bars on i + 3, i + 4 and i + 1.
// (RULE_17) After int32_multiply, four-cycle and dp_multiply barred i + 4..6.
// (RULE_18) After dp-result multiplies, 16x16 multiply barred at i + 7, i + 8.
// (RULE_19) After dp_multiply, four-cycle and 32-bit multiplies barred i + 4..6.
// (RULE_20) After dp_add or dp_sub, bars on i + 5, i + 6 and i + 2, i + 3.
// (RULE_21) Four-cycle class covers single-precision and dp four-cycle operations.
// (RULE_22) Long write port is shared with double_word_load upper word.
// (RULE_23) Long result must issue more than four cycles after double_word_load.
// (RULE_24) Double-precision results write low word one cycle before high.
// (RULE_25) Per-cycle reservation record for read, write and cross path.
module fpulhc_unit (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic ISSUE_VALID,
  input wire fpulhc_pkg::fpulhc_cls_t ISSUE_CLASS,
  input wire logic ISSUE_PRED,
  input wire logic ISSUE_XPATH,
  input wire logic ISSUE_LONG,
  input wire logic XPATH_OTHER,
  input wire logic DWLOAD_ISSUE,
  output logic UNIT_LOCKED,
  output logic XPATH_BUSY,
  output logic READ_PORT_BUSY,
  output logic WR_LO_EN,
  output logic WR_HI_EN,
  output logic LOAD_PORT_WR,
  output logic LONG_PORT_WR,
  output logic RESULT_READY,
  output logic READ_HAZARD,
  output logic WRITE_HAZARD,
  output logic LOCK_VIOLATION,
  output logic XPATH_VIOLATION,
  output logic LONG_PORT_HAZARD,
  output logic CLASS_BARRED,
  output logic ILLEGAL_CLASS
);
  import fpulhc_pkg::*;

  logic legal;
  logic go;
  logic wr_go;
  int cls_idx;
  fpulhc_row_t set_m [FPULHC_NUM_ROW];
  fpulhc_row_t row_v [FPULHC_NUM_ROW];
  fpulhc_row_t rd_all;
  fpulhc_row_t lo_all;
  fpulhc_row_t hi_all;
  fpulhc_row_t ld_all;
  fpulhc_row_t res_all;
  fpulhc_row_t xp_all;
  fpulhc_row_t lp_all;
  logic rd_clash;
  logic wr_clash;
  logic lock_now;
  logic xp_now;
  logic xp_use;
  logic long_now;
  logic bar_now;

  logic unit_locked_ff, nxt_unit_locked;
  logic xpath_busy_ff, nxt_xpath_busy;
  logic read_busy_ff, nxt_read_busy;
  logic wr_lo_ff, nxt_wr_lo;
  logic wr_hi_ff, nxt_wr_hi;
  logic load_wr_ff, nxt_load_wr;
  logic long_wr_ff, nxt_long_wr;
  logic result_ready_ff, nxt_result_ready;
  logic read_hazard_ff, nxt_read_hazard;
  logic write_hazard_ff, nxt_write_hazard;
  logic lock_vio_ff, nxt_lock_vio;
  logic xpath_vio_ff, nxt_xpath_vio;
  logic long_hazard_ff, nxt_long_hazard;
  logic barred_ff, nxt_barred;
  logic illegal_ff, nxt_illegal;

  // Bars an issued class leaves behind against a later target class
  function automatic fpulhc_row_t bar_mask(input fpulhc_cls_t c, input fpulhc_cls_t t);
    fpulhc_row_t m;
    m = '0;
    unique case (c)
      FPULHC_CLS_DP2: begin
        if (t == FPULHC_CLS_SINGLE) m = FPULHC_BAR_DP2_SINGLE; // RULE_14
        if (t == FPULHC_CLS_DP2) m = FPULHC_BAR_DP2_DP2; // RULE_14
      end
      FPULHC_CLS_FOUR: begin
        if (t == FPULHC_CLS_SINGLE) m = FPULHC_BAR_FOUR_SINGLE; // RULE_15
        if (t == FPULHC_CLS_MUL16) m = FPULHC_BAR_FOUR_MUL16; // RULE_15
      end
      FPULHC_CLS_INT_TO_DP: begin
        if (t == FPULHC_CLS_SINGLE) m = FPULHC_BAR_ITD_SINGLE; // RULE_16
        if (t == FPULHC_CLS_INT_TO_DP) m = FPULHC_BAR_ITD_ITD; // RULE_16
        if (t == FPULHC_CLS_FOUR) m = FPULHC_BAR_ITD_FOUR; // RULE_16
      end
      FPULHC_CLS_INT32_MUL: begin
        if (t == FPULHC_CLS_FOUR || t == FPULHC_CLS_DP_MUL) m = FPULHC_BAR_MUL_LATE; // RULE_17
        if (t == FPULHC_CLS_MUL16) m = FPULHC_BAR_I32M_MUL16; // RULE_17
      end
      FPULHC_CLS_INT32_MUL_DP: begin
        if (t == FPULHC_CLS_FOUR || t == FPULHC_CLS_DP_MUL) m = FPULHC_BAR_MUL_LATE;
        if (t == FPULHC_CLS_MUL16) m = FPULHC_BAR_DPM_MUL16; // RULE_18
      end
      FPULHC_CLS_DP_MUL: begin
        if (t == FPULHC_CLS_FOUR || t == FPULHC_CLS_INT32_MUL ||
            t == FPULHC_CLS_INT32_MUL_DP) m = FPULHC_BAR_MUL_LATE; // RULE_19
        if (t == FPULHC_CLS_MUL16) m = FPULHC_BAR_DPM_MUL16; // RULE_18
      end
      FPULHC_CLS_DP_ADD: begin
        if (t == FPULHC_CLS_SINGLE) m = FPULHC_BAR_DPA_SINGLE; // RULE_20
        if (t == FPULHC_CLS_FOUR || t == FPULHC_CLS_INT_TO_DP) m = FPULHC_BAR_DPA_EARLY; // RULE_20
      end
      // These classes bar no later class; their port writes are still recorded
      FPULHC_CLS_SINGLE, FPULHC_CLS_LOAD, FPULHC_CLS_DP_CMP, FPULHC_CLS_MUL16: begin
        m = '0;
      end
      default: begin
        m = '0;
      end
    endcase
    return m;
  endfunction : bar_mask

  // Issue decode and the masks each issue adds to the record
  always_comb begin
    legal = (ISSUE_CLASS <= FPULHC_CLS_MUL16);
    go = ISSUE_VALID && legal; // RULE_07
    // A false predicate makes a nop: no writes, but the read ports stay taken
    wr_go = go && ISSUE_PRED;
    cls_idx = legal ? int'(ISSUE_CLASS) : 0;
    for (int r = 0; r < FPULHC_NUM_ROW; r++) begin
      set_m[r] = '0;
    end
    if (go) begin
      set_m[FPULHC_ROW_RD] = FPULHC_RD_MASK[cls_idx]; // RULE_03 RULE_04 RULE_06 RULE_10 RULE_11
      if (ISSUE_XPATH) begin
        set_m[FPULHC_ROW_XP] = FPULHC_RD_MASK[cls_idx]; // RULE_12
      end
    end
    if (wr_go) begin
      set_m[FPULHC_ROW_LO] = FPULHC_LO_MASK[cls_idx]; // RULE_02 RULE_05 RULE_24
      set_m[FPULHC_ROW_HI] = FPULHC_HI_MASK[cls_idx]; // RULE_05 RULE_24
      set_m[FPULHC_ROW_LD] = FPULHC_LD_MASK[cls_idx]; // RULE_08
      set_m[FPULHC_ROW_RES] = FPULHC_RES_MASK[cls_idx]; // RULE_01 RULE_02 RULE_05 RULE_21
      for (int t = 0; t < FPULHC_NUM_CLS; t++) begin
        set_m[FPULHC_ROW_BAR + t] = bar_mask(ISSUE_CLASS, fpulhc_cls_t'(t));
      end
    end
    if (DWLOAD_ISSUE) begin
      set_m[FPULHC_ROW_LP] = FPULHC_LONG_GUARD; // RULE_22 RULE_23
    end
  end

  // One aging row per kind of resource, plus one bar row per target class
  for (genvar g = 0; g < FPULHC_NUM_ROW; g++) begin : g_rows
    fpulhc_resv_row u_row (
      .SYS_CLK(SYS_CLK),
      .RST_N(RST_N),
      .CLK_EN(CLK_EN),
      .SET_MASK(set_m[g]),
      .ROW(row_v[g])
    ); // RULE_25
  end

  // Merged record: what earlier issues hold plus what this cycle's issue adds
  always_comb begin
    rd_all = row_v[FPULHC_ROW_RD] | set_m[FPULHC_ROW_RD];
    lo_all = row_v[FPULHC_ROW_LO] | set_m[FPULHC_ROW_LO];
    hi_all = row_v[FPULHC_ROW_HI] | set_m[FPULHC_ROW_HI];
    ld_all = row_v[FPULHC_ROW_LD] | set_m[FPULHC_ROW_LD];
    res_all = row_v[FPULHC_ROW_RES] | set_m[FPULHC_ROW_RES];
    xp_all = row_v[FPULHC_ROW_XP] | set_m[FPULHC_ROW_XP];
    lp_all = row_v[FPULHC_ROW_LP] | set_m[FPULHC_ROW_LP];
  end

  // Clash terms compare the new issue with the aged record only, never with itself
  always_comb begin
    rd_clash = |(set_m[FPULHC_ROW_RD] & row_v[FPULHC_ROW_RD]); // RULE_13
    wr_clash = |((set_m[FPULHC_ROW_LO] | set_m[FPULHC_ROW_HI]) &
                 (row_v[FPULHC_ROW_LO] | row_v[FPULHC_ROW_HI])); // RULE_13
    lock_now = row_v[FPULHC_ROW_RD][0]; // RULE_09
    xp_now = row_v[FPULHC_ROW_XP][0]; // RULE_12
    xp_use = (go && ISSUE_XPATH) || XPATH_OTHER;
    long_now = wr_go && ISSUE_LONG; // RULE_22
    bar_now = row_v[FPULHC_ROW_BAR + cls_idx][0]; // RULE_14 RULE_20
  end

  // Lock and cross path look one cycle ahead so dispatch sees them in time
  always_comb begin
    nxt_unit_locked = rd_all[1]; // RULE_11
    nxt_xpath_busy = xp_all[1]; // RULE_12
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      unit_locked_ff <= 1'b0;
      xpath_busy_ff <= 1'b0;
    end else if (CLK_EN) begin
      unit_locked_ff <= nxt_unit_locked;
      xpath_busy_ff <= nxt_xpath_busy;
    end
  end

  // Port strobes describe the previous cycle
  always_comb begin
    nxt_read_busy = rd_all[0];
    nxt_wr_lo = lo_all[0]; // RULE_24
    nxt_wr_hi = hi_all[0]; // RULE_24
    nxt_load_wr = ld_all[0]; // RULE_08
    nxt_long_wr = long_now; // RULE_22
    nxt_result_ready = res_all[0]; // RULE_01
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      read_busy_ff <= 1'b0;
      wr_lo_ff <= 1'b0;
      wr_hi_ff <= 1'b0;
      load_wr_ff <= 1'b0;
      long_wr_ff <= 1'b0;
      result_ready_ff <= 1'b0;
    end else if (CLK_EN) begin
      read_busy_ff <= nxt_read_busy;
      wr_lo_ff <= nxt_wr_lo;
      wr_hi_ff <= nxt_wr_hi;
      load_wr_ff <= nxt_load_wr;
      long_wr_ff <= nxt_long_wr;
      result_ready_ff <= nxt_result_ready;
    end
  end

  // Still reported when the new issue breaks a lock; the outcome is undefined
  always_comb begin
    nxt_read_hazard = rd_clash; // RULE_13
    nxt_write_hazard = wr_clash; // RULE_13
    nxt_lock_vio = ISSUE_VALID && lock_now; // RULE_09
    nxt_xpath_vio = xp_use && xp_now; // RULE_12
    nxt_long_hazard = long_now && lp_all[0]; // RULE_22 RULE_23
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      read_hazard_ff <= 1'b0;
      write_hazard_ff <= 1'b0;
      lock_vio_ff <= 1'b0;
      xpath_vio_ff <= 1'b0;
      long_hazard_ff <= 1'b0;
    end else if (CLK_EN) begin
      read_hazard_ff <= nxt_read_hazard;
      write_hazard_ff <= nxt_write_hazard;
      lock_vio_ff <= nxt_lock_vio;
      xpath_vio_ff <= nxt_xpath_vio;
      long_hazard_ff <= nxt_long_hazard;
    end
  end

  // Bars follow legal issues only; an illegal code records nothing at all
  always_comb begin
    nxt_barred = go && bar_now; // RULE_14 RULE_20
    nxt_illegal = ISSUE_VALID && !legal;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      barred_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end else if (CLK_EN) begin
      barred_ff <= nxt_barred;
      illegal_ff <= nxt_illegal;
    end
  end

  assign UNIT_LOCKED = unit_locked_ff;
  assign XPATH_BUSY = xpath_busy_ff;
  assign READ_PORT_BUSY = read_busy_ff;
  assign WR_LO_EN = wr_lo_ff;
  assign WR_HI_EN = wr_hi_ff;
  assign LOAD_PORT_WR = load_wr_ff;
  assign LONG_PORT_WR = long_wr_ff;
  assign RESULT_READY = result_ready_ff;
  assign READ_HAZARD = read_hazard_ff;
  assign WRITE_HAZARD = write_hazard_ff;
  assign LOCK_VIOLATION = lock_vio_ff;
  assign XPATH_VIOLATION = xpath_vio_ff;
  assign LONG_PORT_HAZARD = long_hazard_ff;
  assign CLASS_BARRED = barred_ff;
  assign ILLEGAL_CLASS = illegal_ff;

endmodule : fpulhc_unit

// [rtl/fpulhc_pkg.sv]
package fpulhc_pkg;

  // Reservation rows look ahead this many cycles, bit k meaning cycle i + k
  localparam int FPULHC_ROW_W = 11;
  localparam int FPULHC_NUM_CLS = 11;

  // Cycle i of every class is the cycle the dispatcher issues, execute_phase_one
  typedef enum logic [3:0] {
    FPULHC_CLS_SINGLE,       // Single-cycle, shared with the fixed-point family
    FPULHC_CLS_DP2,          // Two-cycle double-precision
    FPULHC_CLS_FOUR,         // sp_add, sp_sub, sp_to_int, sp_truncate, int_to_sp, sp_multiply, dp 4-cycle
    FPULHC_CLS_INT_TO_DP,    // int_to_dp_convert
    FPULHC_CLS_LOAD,         // Load on the load/store unit
    FPULHC_CLS_DP_CMP,       // Double-precision compare
    FPULHC_CLS_DP_ADD,       // dp_add and dp_sub
    FPULHC_CLS_INT32_MUL,    // int32_multiply
    FPULHC_CLS_INT32_MUL_DP, // int32_multiply_dp_result
    FPULHC_CLS_DP_MUL,       // dp_multiply
    FPULHC_CLS_MUL16         // 16x16-bit multiply
  } fpulhc_cls_t;

  typedef logic [FPULHC_ROW_W-1:0] fpulhc_row_t;

  // Row indices of the reservation record; bar rows follow, one per target class
  localparam int FPULHC_ROW_RD = 0;
  localparam int FPULHC_ROW_LO = 1;
  localparam int FPULHC_ROW_HI = 2;
  localparam int FPULHC_ROW_LD = 3;
  localparam int FPULHC_ROW_RES = 4;
  localparam int FPULHC_ROW_XP = 5;
  localparam int FPULHC_ROW_LP = 6;
  localparam int FPULHC_ROW_BAR = 7;
  localparam int FPULHC_NUM_ROW = FPULHC_ROW_BAR + FPULHC_NUM_CLS;

  // Per-class masks, in enum order
  localparam fpulhc_row_t FPULHC_RD_MASK [FPULHC_NUM_CLS] = '{
    11'h001, 11'h001, 11'h001, 11'h001, 11'h001, 11'h003,
    11'h003, 11'h00F, 11'h00F, 11'h00F, 11'h001};
  localparam fpulhc_row_t FPULHC_LO_MASK [FPULHC_NUM_CLS] = '{
    11'h001, 11'h001, 11'h008, 11'h008, 11'h001, 11'h002,
    11'h020, 11'h100, 11'h100, 11'h100, 11'h002};
  localparam fpulhc_row_t FPULHC_HI_MASK [FPULHC_NUM_CLS] = '{
    11'h000, 11'h002, 11'h000, 11'h010, 11'h000, 11'h000,
    11'h040, 11'h000, 11'h200, 11'h200, 11'h000};
  localparam fpulhc_row_t FPULHC_LD_MASK [FPULHC_NUM_CLS] = '{
    11'h000, 11'h000, 11'h000, 11'h000, 11'h010, 11'h000,
    11'h000, 11'h000, 11'h000, 11'h000, 11'h000};
  localparam fpulhc_row_t FPULHC_RES_MASK [FPULHC_NUM_CLS] = '{
    11'h002, 11'h004, 11'h010, 11'h020, 11'h020, 11'h004,
    11'h080, 11'h200, 11'h400, 11'h400, 11'h004};

  // Long write port guard after a double_word_load: cycles i + 1 .. i + 4
  localparam fpulhc_row_t FPULHC_LONG_GUARD = 11'h01E;

  // Issue bars left behind by one class against another
  localparam fpulhc_row_t FPULHC_BAR_DP2_SINGLE = 11'h002;
  localparam fpulhc_row_t FPULHC_BAR_DP2_DP2 = 11'h002;
  localparam fpulhc_row_t FPULHC_BAR_FOUR_SINGLE = 11'h008;
  localparam fpulhc_row_t FPULHC_BAR_FOUR_MUL16 = 11'h004;
  localparam fpulhc_row_t FPULHC_BAR_ITD_SINGLE = 11'h018;
  localparam fpulhc_row_t FPULHC_BAR_ITD_ITD = 11'h002;
  localparam fpulhc_row_t FPULHC_BAR_ITD_FOUR = 11'h002;
  localparam fpulhc_row_t FPULHC_BAR_MUL_LATE = 11'h070;
  localparam fpulhc_row_t FPULHC_BAR_I32M_MUL16 = 11'h040;
  localparam fpulhc_row_t FPULHC_BAR_DPM_MUL16 = 11'h180;
  localparam fpulhc_row_t FPULHC_BAR_DPA_SINGLE = 11'h060;
  localparam fpulhc_row_t FPULHC_BAR_DPA_EARLY = 11'h00C;

endpackage : fpulhc_pkg

// [rtl/fpulhc_resv_row.sv]
module fpulhc_resv_row (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire fpulhc_pkg::fpulhc_row_t SET_MASK,
  output fpulhc_pkg::fpulhc_row_t ROW
);
  import fpulhc_pkg::*;

  fpulhc_row_t row_ff;
  fpulhc_row_t nxt_row;

  // Bit 0 is the current cycle; merging then shifting ages the record by one cycle
  always_comb begin
    nxt_row = (row_ff | SET_MASK) >> 1;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      row_ff <= '0;
    end else if (CLK_EN) begin
      row_ff <= nxt_row;
    end
  end

  assign ROW = row_ff;

endmodule : fpulhc_resv_row

// [dv/fpulhc_unit_sva.sv]
module fpulhc_unit_chk (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic ISSUE_VALID,
  input wire fpulhc_pkg::fpulhc_cls_t ISSUE_CLASS,
  input wire logic ISSUE_PRED,
  input wire logic ISSUE_XPATH,
  input wire logic ISSUE_LONG,
  input wire logic DWLOAD_ISSUE,
  input wire logic UNIT_LOCKED,
  input wire logic XPATH_BUSY,
  input wire logic READ_PORT_BUSY,
  input wire logic WR_LO_EN,
  input wire logic WR_HI_EN,
  input wire logic RESULT_READY,
  input wire logic LONG_PORT_WR,
  input wire logic LOCK_VIOLATION,
  input wire logic LONG_PORT_HAZARD
);
  import fpulhc_pkg::*;
  default clocking dc @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  wire go = ISSUE_VALID && ISSUE_PRED;
  wire two = ISSUE_VALID && (ISSUE_CLASS == FPULHC_CLS_DP_ADD || ISSUE_CLASS == FPULHC_CLS_DP_CMP);
  wire mul = ISSUE_VALID && (ISSUE_CLASS == FPULHC_CLS_INT32_MUL ||
    ISSUE_CLASS == FPULHC_CLS_INT32_MUL_DP || ISSUE_CLASS == FPULHC_CLS_DP_MUL);
  single_ready_a: assert property (
    go && ISSUE_CLASS == FPULHC_CLS_SINGLE |=> WR_LO_EN ##1 RESULT_READY)
    else $error("single cycle result not readable next cycle");
  four_write_a: assert property (
    go && ISSUE_CLASS == FPULHC_CLS_FOUR |-> ##4 WR_LO_EN ##1 RESULT_READY)
    else $error("four cycle write or result misplaced");
  dpadd_write_a: assert property (
    go && ISSUE_CLASS == FPULHC_CLS_DP_ADD |-> ##6 WR_LO_EN ##1 WR_HI_EN ##1 RESULT_READY)
    else $error("dp add write or result misplaced");
  dp_lock_a: assert property (
    two |=> UNIT_LOCKED && READ_PORT_BUSY ##1 !UNIT_LOCKED && READ_PORT_BUSY)
    else $error("two cycle lock wrong");
  mul_lock_a: assert property (
    mul |=> UNIT_LOCKED [*3] ##1 !UNIT_LOCKED)
    else $error("multiply lock not four cycles");
  lock_viol_a: assert property (
    LOCK_VIOLATION == $past(ISSUE_VALID && UNIT_LOCKED))
    else $error("lock violation flag wrong");
  xpath_hold_a: assert property (
    mul && ISSUE_XPATH |=> XPATH_BUSY [*3])
    else $error("cross path not held");
  long_haz_a: assert property (
    DWLOAD_ISSUE ##4 (go && ISSUE_LONG) |=> LONG_PORT_HAZARD)
    else $error("long port clash missed");
  long_write_a: assert property (
    go && ISSUE_LONG |=> LONG_PORT_WR)
    else $error("long result write strobe missing");
  dp_pair_a: assert property (
    WR_HI_EN |-> $past(WR_LO_EN))
    else $error("high word without prior low word");
  cover property (go && ISSUE_CLASS == FPULHC_CLS_DP_ADD);
  cover property (LONG_PORT_HAZARD);
  cover property (LOCK_VIOLATION);
  cover property (LONG_PORT_WR);
endmodule : fpulhc_unit_chk

bind fpulhc_unit fpulhc_unit_chk chk_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .ISSUE_VALID(ISSUE_VALID), .ISSUE_CLASS(ISSUE_CLASS), .ISSUE_PRED(ISSUE_PRED),
  .ISSUE_XPATH(ISSUE_XPATH), .ISSUE_LONG(ISSUE_LONG), .DWLOAD_ISSUE(DWLOAD_ISSUE),
  .UNIT_LOCKED(UNIT_LOCKED), .XPATH_BUSY(XPATH_BUSY), .READ_PORT_BUSY(READ_PORT_BUSY),
  .WR_LO_EN(WR_LO_EN), .WR_HI_EN(WR_HI_EN), .RESULT_READY(RESULT_READY),
  .LONG_PORT_WR(LONG_PORT_WR),
  .LOCK_VIOLATION(LOCK_VIOLATION), .LONG_PORT_HAZARD(LONG_PORT_HAZARD));

// [dv/fpulhc_disp_model.sv]
module fpulhc_disp_model (
  input wire logic REQ,
  input wire logic FORCE_ISSUE,
  input wire fpulhc_pkg::fpulhc_cls_t REQ_CLASS,
  input wire logic REQ_PRED,
  input wire logic REQ_XPATH,
  input wire logic REQ_XO,
  input wire logic UNIT_LOCKED,
  input wire logic XPATH_BUSY,
  output logic ISSUE_VALID,
  output fpulhc_pkg::fpulhc_cls_t ISSUE_CLASS,
  output logic ISSUE_PRED,
  output logic ISSUE_XPATH,
  output logic XPATH_OTHER
);
  import fpulhc_pkg::*;
  // Stalls while locked; only a scenario that means harm forces it through
  assign ISSUE_VALID = REQ && (FORCE_ISSUE || !UNIT_LOCKED);
  assign XPATH_OTHER = REQ_XO && (FORCE_ISSUE || !XPATH_BUSY);
  // Idle class and predicate lines show the inverse, not a stale copy the design could lean on
  assign ISSUE_CLASS = ISSUE_VALID ? REQ_CLASS : fpulhc_cls_t'(~REQ_CLASS);
  assign ISSUE_PRED = ISSUE_VALID ? REQ_PRED : ~REQ_PRED;
  assign ISSUE_XPATH = ISSUE_VALID && REQ_XPATH;
endmodule : fpulhc_disp_model

// [dv/fpulhc_unit_bench.sv]
module fpulhc_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import fpulhc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic frc = 1'b0;
  logic pred = 1'b0;
  logic xp = 1'b0;
  logic xo = 1'b0;
  logic lng = 1'b0;
  logic dwl = 1'b0;
  fpulhc_cls_t cls = FPULHC_CLS_SINGLE;
  fpulhc_cls_t iss_cls;
  logic iss_v, iss_p, iss_x, xo_w, lock, xbusy, rdb, wlo, whi, ldw, rdy;
  logic [6:0] haz;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;

  fpulhc_disp_model disp_u (.REQ(req), .FORCE_ISSUE(frc), .REQ_CLASS(cls), .REQ_PRED(pred),
    .REQ_XPATH(xp), .REQ_XO(xo), .UNIT_LOCKED(lock), .XPATH_BUSY(xbusy), .ISSUE_VALID(iss_v),
    .ISSUE_CLASS(iss_cls), .ISSUE_PRED(iss_p), .ISSUE_XPATH(iss_x), .XPATH_OTHER(xo_w));

  fpulhc_unit dut_u (.SYS_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .ISSUE_VALID(iss_v),
    .ISSUE_CLASS(iss_cls), .ISSUE_PRED(iss_p), .ISSUE_XPATH(iss_x), .ISSUE_LONG(lng),
    .XPATH_OTHER(xo_w), .DWLOAD_ISSUE(dwl), .UNIT_LOCKED(lock), .XPATH_BUSY(xbusy),
    .READ_PORT_BUSY(rdb), .WR_LO_EN(wlo), .WR_HI_EN(whi), .LOAD_PORT_WR(ldw),
    .LONG_PORT_WR(), .RESULT_READY(rdy), .READ_HAZARD(haz[0]), .WRITE_HAZARD(haz[1]),
    .LOCK_VIOLATION(haz[2]), .XPATH_VIOLATION(haz[3]), .LONG_PORT_HAZARD(haz[4]),
    .CLASS_BARRED(haz[5]), .ILLEGAL_CLASS(haz[6]));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic test_done();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [71:0] e, input logic [71:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  // Mode: 0 plain, 1 long result, 2 cross path, 3 load only, 4 other cross path, 5 idle
  task automatic drive(input fpulhc_cls_t c, input logic p, input logic [2:0] m);
    req <= m < 3'd3;
    cls <= c;
    pred <= p;
    lng <= m == 3'd1;
    xp <= m == 3'd2;
    dwl <= m == 3'd3;
    xo <= m == 3'd4;
  endtask : drive

  // Rows {lock, read, low, high, ready, load port}, bit k is cycle i + k for lock and cycle i + k - 1 for the others
  task automatic run(input fpulhc_cls_t c, input logic p, input logic [71:0] e);
    logic [71:0] g;
    g = '0;
    repeat (12) @(posedge clk);
    frc <= 1'b0;
    drive(c, p, 3'd0);
    for (int k = 1; k < 12; k++) begin
      @(posedge clk);
      drive(c, 1'b0, 3'd5);
      #1;
      g[60+k] = lock;
      g[48+k] = rdb;
      g[36+k] = wlo;
      g[24+k] = whi;
      g[12+k] = rdy;
      g[k] = ldw;
    end
    chk(e, g);
  endtask : run

  // Hazard pulses are collected over the window since they last one cycle only
  task automatic pair(input fpulhc_cls_t a, input logic [2:0] ma, input int gap,
      input fpulhc_cls_t b, input logic [2:0] mb, input logic [6:0] e);
    logic [6:0] h;
    h = '0;
    repeat (14) @(posedge clk);
    frc <= 1'b1;
    drive(a, 1'b1, ma);
    for (int k = 1; k < gap + 4; k++) begin
      @(posedge clk);
      if (k == gap)
        drive(b, 1'b1, mb);
      else
        drive(b, 1'b0, 3'd5);
      #1;
      h = h | haz;
    end
    chk({65'd0, e}, {65'd0, h});
  endtask : pair

  task automatic t_profiles();
    run(FPULHC_CLS_SINGLE, 1'b1, 72'h000_002_002_000_004_000);
    run(FPULHC_CLS_DP2, 1'b1, 72'h000_002_002_004_008_000);
    run(FPULHC_CLS_FOUR, 1'b1, 72'h000_002_010_000_020_000);
    run(FPULHC_CLS_INT_TO_DP, 1'b1, 72'h000_002_010_020_040_000);
    run(FPULHC_CLS_LOAD, 1'b1, 72'h000_002_002_000_040_020);
    run(FPULHC_CLS_DP_CMP, 1'b1, 72'h002_006_004_000_008_000);
    run(FPULHC_CLS_DP_ADD, 1'b1, 72'h002_006_040_080_100_000);
    run(FPULHC_CLS_INT32_MUL, 1'b1, 72'h00E_01E_200_000_400_000);
    run(FPULHC_CLS_INT32_MUL_DP, 1'b1, 72'h00E_01E_200_400_800_000);
    run(FPULHC_CLS_DP_MUL, 1'b1, 72'h00E_01E_200_400_800_000);
    run(FPULHC_CLS_MUL16, 1'b1, 72'h000_002_004_000_008_000);
    run(FPULHC_CLS_DP_MUL, 1'b0, 72'h00E_01E_000_000_000_000);
  endtask : t_profiles

  task automatic t_hazards();
    pair(FPULHC_CLS_SINGLE, 3'd0, 1, FPULHC_CLS_SINGLE, 3'd0, 7'h00);
    pair(FPULHC_CLS_DP2, 3'd0, 1, FPULHC_CLS_SINGLE, 3'd0, 7'h22);
    pair(FPULHC_CLS_FOUR, 3'd0, 2, FPULHC_CLS_MUL16, 3'd0, 7'h22);
    pair(FPULHC_CLS_INT_TO_DP, 3'd0, 4, FPULHC_CLS_SINGLE, 3'd0, 7'h22);
    pair(FPULHC_CLS_INT32_MUL, 3'd0, 5, FPULHC_CLS_DP_MUL, 3'd0, 7'h20);
    pair(FPULHC_CLS_DP_MUL, 3'd0, 7, FPULHC_CLS_MUL16, 3'd0, 7'h22);
    pair(FPULHC_CLS_DP_MUL, 3'd0, 4, FPULHC_CLS_INT32_MUL, 3'd0, 7'h20);
    pair(FPULHC_CLS_DP_ADD, 3'd0, 2, FPULHC_CLS_FOUR, 3'd0, 7'h22);
    pair(FPULHC_CLS_DP_ADD, 3'd0, 1, FPULHC_CLS_SINGLE, 3'd0, 7'h05);
  endtask : t_hazards

  task automatic t_side();
    pair(FPULHC_CLS_SINGLE, 3'd3, 4, FPULHC_CLS_SINGLE, 3'd1, 7'h10);
    pair(FPULHC_CLS_SINGLE, 3'd3, 5, FPULHC_CLS_SINGLE, 3'd1, 7'h00);
    pair(FPULHC_CLS_DP_MUL, 3'd2, 3, FPULHC_CLS_SINGLE, 3'd4, 7'h08);
    pair(FPULHC_CLS_DP_MUL, 3'd2, 4, FPULHC_CLS_SINGLE, 3'd4, 7'h00);
    pair(FPULHC_CLS_SINGLE, 3'd0, 2, fpulhc_cls_t'(4'hF), 3'd0, 7'h40);
  endtask : t_side

  // Ceiling leaves about five times the cycles the scenarios need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_profiles();
    t_hazards();
    t_side();
    test_done();
  end
endmodule : fpulhc_unit_bench
